// ===== src/ecmx_pkg.sv
// constants, types and register map of the extended channel mux block
package ecmx_pkg;

   // ***************************************************************
   // clock and timing
   // ***************************************************************
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned US_PER_S = 1_000_000;
   localparam int unsigned US_CYCLES = CLK_HZ / US_PER_S;
   localparam logic [7:0] US_LAST = 8'(US_CYCLES - 1);

   // ***************************************************************
   // channel map
   // ***************************************************************
   localparam int unsigned NUM_EXT = 80;
   localparam logic [6:0] EXT_FIRST = 7'h10;
   localparam logic [6:0] ARRAY_FIRST = 7'h30;
   localparam logic [15:0] PAIR_FIRST = 16'h0038;

   // ***************************************************************
   // register indices of the host protocol
   // ***************************************************************
   localparam logic [15:0] VOLT_BASE = 16'h0060;
   localparam logic [15:0] SCAN_SETTLE_ADDR = 16'h0fa8;
   localparam logic [15:0] SCAN_RES_ADDR = 16'h0faa;
   localparam logic [15:0] SPAN_BASE = 16'h9ca0;
   localparam logic [15:0] NEG_BASE = 16'ha058;
   localparam logic [15:0] RES_BASE = 16'ha24c;
   localparam logic [15:0] SETTLE_BASE = 16'ha470;
   localparam logic [15:0] G_SPAN_ADDR = 16'hab7c;
   localparam logic [15:0] G_NEG_ADDR = 16'hab7e;
   localparam logic [15:0] G_RES_ADDR = 16'hab7f;
   localparam logic [15:0] G_SETTLE_ADDR = 16'hab80;

   // ***************************************************************
   // values
   // ***************************************************************
   localparam logic [15:0] NEG_SINGLE = 16'h00c7;
   localparam logic [15:0] NEG_DIFF = 16'h0001;
   localparam logic [15:0] MIXED_16 = 16'hffff;
   localparam logic [31:0] MIXED_F = 32'hc61c3c00;
   localparam logic [31:0] SETTLE_MAX_F = 32'h47435000;
   localparam logic [31:0] ONE_F = 32'h3f800000;
   localparam logic [31:0] SCAN_SETTLE_RST = 32'h00000000;
   localparam logic [31:0] SCAN_RES_RST = 32'h00000000;
   localparam logic [7:0] F_EXP_ONE = 8'h7f;
   localparam logic [7:0] F_EXP_INT = 8'h96;
   localparam logic [7:0] F_EXP_MAX = 8'h9e;

   // ***************************************************************
   // state
   // ***************************************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SETTLE = 3'b010,
      ST_WAIT = 3'b100
   } ecmx_state_e;

   typedef struct packed {
      ecmx_state_e st;
      logic [NUM_EXT-1:0][15:0] neg;
      logic [NUM_EXT-1:0][15:0] res;
      logic [NUM_EXT-1:0][31:0] span;
      logic [NUM_EXT-1:0][31:0] settle;
      logic [31:0] scan_settle;
      logic [31:0] scan_res;
      logic [15:0] us_left;
      logic [7:0] div;
      logic scan_job;
      logic [31:0] rdata;
      logic rvalid;
      logic svalid;
      logic busy;
      logic start;
      logic diff;
      logic [2:0] sel;
      logic [3:0] chan;
      logic [3:0] nchan;
      logic [15:0] cres;
      logic [31:0] cspan;
   } ecmx_state_s;

   localparam ecmx_state_s STATE_RST = '{
      st: ST_IDLE,
      neg: {NUM_EXT{NEG_SINGLE}},
      scan_settle: SCAN_SETTLE_RST,
      scan_res: SCAN_RES_RST,
      default: '0
   };

endpackage

// ===== src/ecmx_f2u_if.sv
// carrier between the control block and the float to integer converter
interface ecmx_f2u_if;
   logic [31:0] fval;
   logic [31:0] whole;
   modport conv (input fval, output whole);
   modport user (output fval, input whole);
endinterface

// ===== src/ecmx_f2u.sv
// float32 to unsigned whole microseconds, truncating, negatives to zero
module ecmx_f2u (
   ecmx_f2u_if.conv bus
);
   logic [7:0] expo;
   logic [23:0] mant;

   assign expo = bus.fval[30:23];
   assign mant = {1'b1, bus.fval[22:0]};

   always_comb begin
      if (bus.fval[31] || (expo < ecmx_pkg::F_EXP_ONE)) begin
         bus.whole = 32'h00000000;
      end else if (expo > ecmx_pkg::F_EXP_MAX) begin
         bus.whole = 32'hffffffff;
      end else if (expo >= ecmx_pkg::F_EXP_INT) begin
         bus.whole = {8'h00, mant} << (expo - ecmx_pkg::F_EXP_INT);
      end else begin
         bus.whole = {8'h00, mant} >> (ecmx_pkg::F_EXP_INT - expo);
      end
   end
endmodule

// ===== src/ecmx_top.sv
// extended channel mux control: config registers, select lines, settling
module ecmx_top #(
   parameter int unsigned AUTO_SETTLE_US = 10
) (
   input wire logic SYS_CLK_I,
   input wire logic RESETN_I,
   input wire logic [15:0] REG_ADDR_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [31:0] REG_WDATA_I,
   output logic [31:0] REG_RDATA_O,
   output logic REG_RVALID_O,
   output logic BUSY_O,
   input wire logic SCAN_REQ_I,
   input wire logic [6:0] SCAN_CHAN_I,
   input wire logic SCAN_FIRST_I,
   output logic SCAN_VALID_O,
   output logic [2:0] MUX_SEL_O,
   output logic CONV_START_O,
   output logic [3:0] CONV_CHAN_O,
   output logic [3:0] CONV_NEG_O,
   output logic CONV_DIFF_O,
   output logic [15:0] CONV_RES_O,
   output logic [31:0] CONV_SPAN_O,
   input wire logic CONV_DONE_I,
   input wire logic [31:0] CONV_DATA_I
);
   localparam int unsigned N = ecmx_pkg::NUM_EXT;

   // ***************************************************************
   // elaboration checks
   // ***************************************************************
   if (AUTO_SETTLE_US > 65535) begin : g_chk_auto
      $error("AUTO_SETTLE_US does not fit the settle counter");
   end
   if ((ecmx_pkg::US_CYCLES < 1) || (ecmx_pkg::US_CYCLES > 256))
   begin : g_chk_div
      $error("microsecond divider out of range");
   end

   ecmx_pkg::ecmx_state_s s;
   ecmx_pkg::ecmx_state_s n;

   // ***************************************************************
   // array address decode
   // ***************************************************************
   function automatic logic [7:0] arr_hit(input logic [15:0] a,
      input logic [15:0] base, input logic wide);
      logic [15:0] off;
      off = a - base;
      if (wide) begin
         arr_hit = {(a >= base) && (off < 16'(2 * N)) && !off[0],
            off[7:1]};
      end else begin
         arr_hit = {(a >= base) && (off < 16'(N)), off[6:0]};
      end
   endfunction

   logic [7:0] volt_hit;
   logic [7:0] neg_hit;
   logic [7:0] res_hit;
   logic [7:0] span_hit;
   logic [7:0] set_hit;

   assign volt_hit = arr_hit(REG_ADDR_I, ecmx_pkg::VOLT_BASE, 1'b1);
   assign neg_hit = arr_hit(REG_ADDR_I, ecmx_pkg::NEG_BASE, 1'b0);
   assign res_hit = arr_hit(REG_ADDR_I, ecmx_pkg::RES_BASE, 1'b0);
   assign span_hit = arr_hit(REG_ADDR_I, ecmx_pkg::SPAN_BASE, 1'b1);
   assign set_hit = arr_hit(REG_ADDR_I, ecmx_pkg::SETTLE_BASE, 1'b1);

   // ***************************************************************
   // per-entry consistency flags
   // ***************************************************************
   logic [N-1:0] res_eq;
   logic [N-1:0] span_eq;
   logic [N-1:0] set_eq;
   logic [N-1:0] is_se;
   logic [N-1:0] diff_ok;
   logic [N-1:0] cap;

   for (genvar g = 0; g < N; g++) begin : g_ent
      // positive-capable: lower eight of each group of sixteen
      assign cap[g] = (((g / 8) % 2) == 0);
      assign res_eq[g] = (s.res[g] == s.res[0]);
      assign span_eq[g] = (s.span[g] == s.span[0]);
      assign set_eq[g] = (s.settle[g] == s.settle[0]);
      assign is_se[g] = (s.neg[g] == ecmx_pkg::NEG_SINGLE);
      assign diff_ok[g] = !cap[g] || !is_se[g];
   end

   // ***************************************************************
   // job decode
   // ***************************************************************
   logic idle;
   logic rd_go;
   logic wr_go;
   logic conv_go;
   logic sc_go;
   logic [6:0] job_idx;
   logic [6:0] job_ext;
   logic [6:0] job_rel;
   logic job_diff;
   logic scan_auto;
   logic [15:0] settle_sat;
   logic [15:0] job_us;
   logic [15:0] wv16;
   logic [15:0] pair_val;
   logic [31:0] settle_lim;
   ecmx_f2u_if f2u_bus ();

   assign idle = (s.st == ecmx_pkg::ST_IDLE);
   assign rd_go = idle && REG_RD_I;
   assign wr_go = idle && REG_WR_I && !REG_RD_I;
   assign conv_go = rd_go && volt_hit[7];
   assign sc_go = idle && !REG_RD_I && !REG_WR_I && SCAN_REQ_I
      && (SCAN_CHAN_I >= ecmx_pkg::ARRAY_FIRST);
   assign job_idx = sc_go ? 7'(SCAN_CHAN_I - ecmx_pkg::ARRAY_FIRST)
      : volt_hit[6:0];
   assign job_ext = job_idx + ecmx_pkg::ARRAY_FIRST;
   assign job_rel = job_ext - ecmx_pkg::EXT_FIRST;
   assign job_diff = (s.neg[job_idx] != ecmx_pkg::NEG_SINGLE);

   assign f2u_bus.fval = sc_go ? s.scan_settle : s.settle[job_idx];
   assign settle_sat = (f2u_bus.whole > 32'h0000ffff) ? 16'hffff
      : f2u_bus.whole[15:0];
   assign scan_auto = s.scan_settle[31]
      || (s.scan_settle < ecmx_pkg::ONE_F);
   assign job_us = !sc_go ? settle_sat
      : SCAN_FIRST_I ? 16'h0000
      : scan_auto ? 16'(AUTO_SETTLE_US) : settle_sat;

   assign wv16 = REG_WDATA_I[15:0];
   assign pair_val = {9'h000, neg_hit[6:0]} + ecmx_pkg::PAIR_FIRST;
   assign settle_lim = (!REG_WDATA_I[31]
      && (REG_WDATA_I > ecmx_pkg::SETTLE_MAX_F))
      ? ecmx_pkg::SETTLE_MAX_F : REG_WDATA_I;

   ecmx_f2u u_f2u (
      .bus(f2u_bus.conv)
   );

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      n = s;
      n.rvalid = 1'b0;
      n.svalid = 1'b0;
      n.start = 1'b0;
      case (s.st)
         ecmx_pkg::ST_IDLE: begin
            if (conv_go || sc_go) begin
               n.scan_job = sc_go;
               // built-in input reached only through its mux
               n.chan = job_rel[6:3];
               n.sel = job_rel[2:0];
               n.diff = job_diff;
               // pair partner sits on the next built-in input
               n.nchan = job_diff ? job_rel[6:3] + 4'h1
                  : 4'h0;
               n.cres = sc_go ? s.scan_res[15:0]
                  : s.res[job_idx];
               n.cspan = s.span[job_idx];
               n.us_left = job_us;
               n.div = 8'h00;
               n.busy = 1'b1;
               n.st = ecmx_pkg::ST_SETTLE;
            end else if (rd_go) begin
               n.rvalid = 1'b1;
               n.rdata = 32'h00000000;
               if (neg_hit[7]) begin
                  n.rdata = {16'h0000, s.neg[neg_hit[6:0]]};
               end else if (res_hit[7]) begin
                  n.rdata = {16'h0000, s.res[res_hit[6:0]]};
               end else if (span_hit[7]) begin
                  n.rdata = s.span[span_hit[6:0]];
               end else if (set_hit[7]) begin
                  n.rdata = s.settle[set_hit[6:0]];
               end else begin
                  case (REG_ADDR_I)
                     ecmx_pkg::G_NEG_ADDR: begin
                        n.rdata[15:0] = (&is_se) ? ecmx_pkg::NEG_SINGLE
                           : (&diff_ok) ? ecmx_pkg::NEG_DIFF
                           : ecmx_pkg::MIXED_16;
                     end
                     ecmx_pkg::G_RES_ADDR: begin
                        n.rdata[15:0] = (&res_eq) ? s.res[0]
                           : ecmx_pkg::MIXED_16;
                     end
                     ecmx_pkg::G_SPAN_ADDR: begin
                        n.rdata = (&span_eq) ? s.span[0]
                           : ecmx_pkg::MIXED_F;
                     end
                     ecmx_pkg::G_SETTLE_ADDR: begin
                        n.rdata = (&set_eq) ? s.settle[0]
                           : ecmx_pkg::MIXED_F;
                     end
                     ecmx_pkg::SCAN_SETTLE_ADDR: begin
                        n.rdata = s.scan_settle;
                     end
                     ecmx_pkg::SCAN_RES_ADDR: begin
                        n.rdata = s.scan_res;
                     end
                     default: begin
                        n.rdata = 32'h00000000;
                     end
                  endcase
               end
            end else if (wr_go) begin
               if (neg_hit[7]) begin
                  // only single-ended or the exact plus-eight partner
                  if ((wv16 == ecmx_pkg::NEG_SINGLE) || (cap[neg_hit[6:0]]
                     && (wv16 == pair_val))) begin
                     n.neg[neg_hit[6:0]] = wv16;
                  end
               end else if (res_hit[7]) begin
                  n.res[res_hit[6:0]] = wv16;
               end else if (span_hit[7]) begin
                  n.span[span_hit[6:0]] = REG_WDATA_I;
               end else if (set_hit[7]) begin
                  n.settle[set_hit[6:0]] = REG_WDATA_I;
               end else begin
                  case (REG_ADDR_I)
                     ecmx_pkg::G_NEG_ADDR: begin
                        for (int i = 0; i < N; i++) begin
                           if (wv16 == ecmx_pkg::NEG_DIFF) begin
                              n.neg[i] = cap[i] ? 16'(i) + ecmx_pkg::PAIR_FIRST
                                 : ecmx_pkg::NEG_SINGLE;
                           end else if (wv16 == ecmx_pkg::NEG_SINGLE) begin
                              n.neg[i] = ecmx_pkg::NEG_SINGLE;
                           end
                        end
                     end
                     ecmx_pkg::G_RES_ADDR: begin
                        for (int i = 0; i < N; i++) begin
                           n.res[i] = wv16;
                        end
                     end
                     ecmx_pkg::G_SPAN_ADDR: begin
                        for (int i = 0; i < N; i++) begin
                           n.span[i] = REG_WDATA_I;
                        end
                     end
                     ecmx_pkg::G_SETTLE_ADDR: begin
                        for (int i = 0; i < N; i++) begin
                           n.settle[i] = settle_lim;
                        end
                     end
                     ecmx_pkg::SCAN_SETTLE_ADDR: begin
                        n.scan_settle = REG_WDATA_I;
                     end
                     ecmx_pkg::SCAN_RES_ADDR: begin
                        n.scan_res = REG_WDATA_I;
                     end
                     default: begin
                        n.scan_res = s.scan_res;
                     end
                  endcase
               end
            end
         end
         ecmx_pkg::ST_SETTLE: begin
            // select lines already stable; count settling in whole us
            if (s.us_left == 16'h0000) begin
               n.start = 1'b1;
               n.st = ecmx_pkg::ST_WAIT;
            end else if (s.div == ecmx_pkg::US_LAST) begin
               n.div = 8'h00;
               n.us_left = s.us_left - 16'h0001;
            end else begin
               n.div = s.div + 8'h01;
            end
         end
         ecmx_pkg::ST_WAIT: begin
            if (CONV_DONE_I) begin
               n.rdata = CONV_DATA_I;
               n.rvalid = !s.scan_job;
               n.svalid = s.scan_job;
               n.busy = 1'b0;
               n.st = ecmx_pkg::ST_IDLE;
            end
         end
         default: begin
            n.busy = 1'b0;
            n.st = ecmx_pkg::ST_IDLE;
         end
      endcase
   end

   // ***************************************************************
   // state register
   // ***************************************************************
   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         s <= ecmx_pkg::STATE_RST;
      end else begin
         s <= n;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign REG_RDATA_O = s.rdata;
   assign REG_RVALID_O = s.rvalid;
   assign BUSY_O = s.busy;
   assign SCAN_VALID_O = s.svalid;
   assign MUX_SEL_O = s.sel;
   assign CONV_START_O = s.start;
   assign CONV_CHAN_O = s.chan;
   assign CONV_NEG_O = s.nchan;
   assign CONV_DIFF_O = s.diff;
   assign CONV_RES_O = s.cres;
   assign CONV_SPAN_O = s.cspan;
endmodule

// ===== tb/ecmx_conv_model.sv
// converter and external mux stand-in answering conversion starts
module ecmx_conv_model (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic start_i,
   input wire logic [2:0] sel_i,
   input wire logic [3:0] chan_i,
   output logic done_o,
   output logic [31:0] data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ***************************************************************
   // answer each start, alternately fast and slow
   // ***************************************************************
   logic [31:0] last;
   bit slow;
   initial begin
      done_o = 1'b0;
      data_o = 32'h0;
      last = 32'h0;
      slow = 1'b0;
      forever begin
         @(negedge clk_i);
         if (rstn_i === 1'b1 && start_i === 1'b1) begin
            // routed input shows up in the reading
            last = {16'ha500, 4'h0, chan_i, 5'h0, sel_i};
            repeat (slow ? 6 : 1) @(posedge clk_i);
            #1;
            done_o = 1'b1;
            data_o = last;
            @(posedge clk_i);
            #1;
            done_o = 1'b0;
            data_o = ~last;
            slow = !slow;
         end
      end
   end
endmodule

// ===== tb/ecmx_top_monitor.sv
// concurrent checks on the ports of the extended channel mux block
module ecmx_top_monitor #(
   parameter int unsigned AUTO_SETTLE_US = 10
) (
   input wire logic SYS_CLK_I,
   input wire logic RESETN_I,
   input wire logic [15:0] REG_ADDR_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [31:0] REG_RDATA_O,
   input wire logic REG_RVALID_O,
   input wire logic BUSY_O,
   input wire logic SCAN_REQ_I,
   input wire logic [6:0] SCAN_CHAN_I,
   input wire logic SCAN_FIRST_I,
   input wire logic SCAN_VALID_O,
   input wire logic [2:0] MUX_SEL_O,
   input wire logic CONV_START_O,
   input wire logic [3:0] CONV_CHAN_O,
   input wire logic [3:0] CONV_NEG_O,
   input wire logic CONV_DIFF_O,
   input wire logic CONV_DONE_I,
   input wire logic [31:0] CONV_DATA_I
);
   // ***************************************************************
   // helpers and properties
   // ***************************************************************
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RESETN_I);
   logic [15:0] k;
   logic is_volt;
   logic vrd;
   assign k = REG_ADDR_I - ecmx_pkg::VOLT_BASE;
   assign is_volt = REG_ADDR_I >= ecmx_pkg::VOLT_BASE && k < 16'h00a0
      && !REG_ADDR_I[0];
   assign vrd = REG_RD_I && !BUSY_O && is_volt;
   sequence done_in;
      CONV_DONE_I && BUSY_O;
   endsequence
   sequence answer;
      (REG_RVALID_O || SCAN_VALID_O) && !BUSY_O;
   endsequence
   sequence scan_first;
      SCAN_REQ_I && SCAN_FIRST_I && !REG_RD_I && !REG_WR_I && !BUSY_O
         && SCAN_CHAN_I >= 7'h30;
   endsequence
   AST_CFG_ANSWER: assert property (REG_RD_I && !BUSY_O && !is_volt
      |=> REG_RVALID_O && !BUSY_O) else $error("config read unanswered");
   AST_VOLT_SEL: assert property (vrd |=> BUSY_O
      && MUX_SEL_O == $past(k[3:1])) else $error("select code wrong");
   AST_VOLT_CHAN: assert property (vrd |=>
      CONV_CHAN_O == 4'h4 + $past(k[7:4])) else $error("built-in wrong");
   AST_SEL_HOLD: assert property (BUSY_O && $past(BUSY_O) |->
      $stable(MUX_SEL_O) && $stable(CONV_CHAN_O)) else $error("sel moved");
   AST_START_PULSE: assert property (CONV_START_O |-> BUSY_O
      ##1 !CONV_START_O) else $error("start not a pulse in a job");
   AST_DIFF_PAIR: assert property (CONV_START_O && CONV_DIFF_O |->
      CONV_NEG_O == CONV_CHAN_O + 4'h1 && !CONV_CHAN_O[0])
      else $error("bad differential pair");
   AST_SINGLE_NEG: assert property (CONV_START_O && !CONV_DIFF_O |->
      CONV_NEG_O == 4'h0) else $error("single-ended negative not zero");
   AST_DONE_DATA: assert property (done_in |=> answer
      ##0 REG_RDATA_O == $past(CONV_DATA_I)) else $error("result lost");
   AST_SCAN_FIRST: assert property (scan_first |=> BUSY_O
      ##1 CONV_START_O) else $error("first scan channel settled");
endmodule
bind ecmx_top ecmx_top_monitor #(.AUTO_SETTLE_US(AUTO_SETTLE_US)) u_mon (
   .SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I), .REG_ADDR_I(REG_ADDR_I),
   .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
   .REG_RVALID_O(REG_RVALID_O), .BUSY_O(BUSY_O), .SCAN_REQ_I(SCAN_REQ_I),
   .SCAN_CHAN_I(SCAN_CHAN_I), .SCAN_FIRST_I(SCAN_FIRST_I),
   .SCAN_VALID_O(SCAN_VALID_O), .MUX_SEL_O(MUX_SEL_O),
   .CONV_START_O(CONV_START_O), .CONV_CHAN_O(CONV_CHAN_O),
   .CONV_NEG_O(CONV_NEG_O), .CONV_DIFF_O(CONV_DIFF_O),
   .CONV_DONE_I(CONV_DONE_I), .CONV_DATA_I(CONV_DATA_I));

// ===== tb/tb.sv
// self-checking bench of the extended channel mux control block
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ***************************************************************
   // signals, clock, design and converter stand-in
   // ***************************************************************
   logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, sreq = 1'b0;
   logic sfirst = 1'b0, rvalid, busy, svalid, start, cdiff, done;
   logic [15:0] addr = 16'h0, cres;
   logic [31:0] wdata = 32'h0, rdata, cspan, cdata;
   logic [6:0] schan = 7'h30;
   logic [2:0] sel;
   logic [3:0] cchan, cneg;
   int fails = 0, tests_run = 0;
   initial forever #4 clk = ~clk;
   ecmx_top #(.AUTO_SETTLE_US(1)) uut (.SYS_CLK_I(clk), .RESETN_I(rstn),
      .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd), .REG_WDATA_I(wdata),
      .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .BUSY_O(busy),
      .SCAN_REQ_I(sreq), .SCAN_CHAN_I(schan), .SCAN_FIRST_I(sfirst),
      .SCAN_VALID_O(svalid), .MUX_SEL_O(sel), .CONV_START_O(start),
      .CONV_CHAN_O(cchan), .CONV_NEG_O(cneg), .CONV_DIFF_O(cdiff),
      .CONV_RES_O(cres), .CONV_SPAN_O(cspan), .CONV_DONE_I(done),
      .CONV_DATA_I(cdata));
   ecmx_conv_model conv (.clk_i(clk), .rstn_i(rstn), .start_i(start),
      .sel_i(sel), .chan_i(cchan), .done_o(done), .data_o(cdata));
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      if (fails == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic reg_wr(input logic [15:0] a, input logic [31:0] v);
      addr = a;
      wdata = v;
      wr = 1'b1;
      tick();
      wr = 1'b0;
      tick();
   endtask
   task automatic reg_rd(input logic [15:0] a, input logic [31:0] exp);
      int n;
      addr = a;
      rd = 1'b1;
      tick();
      rd = 1'b0;
      for (n = 0; n < 50 && rvalid !== 1'b1; n++) tick();
      check({31'h0, rvalid}, 32'h1);
      check(rdata, exp);
      tick();
   endtask
   // one voltage read or scan conversion, start latency checked
   task automatic job(input bit scan, input int ch, input bit first,
      input int exp_n);
      int n;
      if (scan) begin
         sreq = 1'b1;
         schan = 7'(ch);
         sfirst = first;
      end else begin
         rd = 1'b1;
         addr = ecmx_pkg::VOLT_BASE + 16'(2 * (ch - 48));
      end
      tick();
      sreq = 1'b0;
      rd = 1'b0;
      for (n = 1; start !== 1'b1 && n < 2000; n++) tick();
      check(32'(n), 32'(exp_n));
      check({29'h0, sel}, 32'((ch - 16) % 8));
      check({28'h0, cchan}, 32'((ch - 16) / 8));
      while ((scan ? svalid : rvalid) !== 1'b1 && n < 3000) begin
         tick();
         n++;
      end
      check({29'h0, busy, svalid, rvalid}, scan ? 32'h2 : 32'h1);
      check(rdata, {16'ha500, 4'h0, 4'((ch - 16) / 8), 5'h0,
         3'((ch - 16) % 8)});
      tick();
   endtask
   // ***************************************************************
   // scenarios
   // ***************************************************************
   task automatic t_reset_values();
      reg_rd(ecmx_pkg::NEG_BASE, 32'h0000_00c7);
      reg_rd(ecmx_pkg::G_NEG_ADDR, 32'h0000_00c7);
      reg_rd(ecmx_pkg::SCAN_SETTLE_ADDR, 32'h0);
      reg_rd(ecmx_pkg::SCAN_RES_ADDR, 32'h0);
      reg_rd(16'h1234, 32'h0);
   endtask
   task automatic t_global_neg();
      reg_wr(ecmx_pkg::G_NEG_ADDR, 32'h1);
      reg_rd(ecmx_pkg::G_NEG_ADDR, 32'h1);
      reg_rd(ecmx_pkg::NEG_BASE, 32'h38);
      reg_rd(ecmx_pkg::NEG_BASE + 16'h8, 32'hc7);
      reg_wr(ecmx_pkg::G_NEG_ADDR, 32'h5);
      reg_rd(ecmx_pkg::G_NEG_ADDR, 32'h1);
      reg_wr(ecmx_pkg::NEG_BASE, 32'hc7);
      reg_rd(ecmx_pkg::G_NEG_ADDR, 32'hffff);
      reg_wr(ecmx_pkg::NEG_BASE, 32'h38);
   endtask
   task automatic t_res_span();
      reg_wr(ecmx_pkg::G_RES_ADDR, 32'h3);
      reg_rd(ecmx_pkg::RES_BASE + 16'd22, 32'h3);
      reg_wr(ecmx_pkg::RES_BASE + 16'd22, 32'h7);
      reg_rd(ecmx_pkg::G_RES_ADDR, 32'hffff);
      reg_wr(ecmx_pkg::SCAN_RES_ADDR, 32'h1234_5678);
      reg_rd(ecmx_pkg::SCAN_RES_ADDR, 32'h1234_5678);
      reg_rd(ecmx_pkg::G_RES_ADDR, 32'hffff);
      reg_wr(ecmx_pkg::G_SPAN_ADDR, 32'h40a0_0000);
      reg_rd(ecmx_pkg::SPAN_BASE + 16'd158, 32'h40a0_0000);
      reg_rd(ecmx_pkg::SPAN_BASE + 16'd159, 32'h0);
      reg_wr(ecmx_pkg::SPAN_BASE, ecmx_pkg::ONE_F);
      reg_rd(ecmx_pkg::G_SPAN_ADDR, ecmx_pkg::MIXED_F);
   endtask
   task automatic t_sweep();
      bit df;
      reg_wr(ecmx_pkg::G_SETTLE_ADDR, 32'h0);
      for (int ch = 48; ch < 128; ch++) begin
         job(1'b0, ch, 1'b0, 2);
         df = (((ch - 16) >> 3) % 2) == 0;
         check({31'h0, cdiff}, {31'h0, df});
         check({28'h0, cneg}, df ? 32'((ch - 16) / 8 + 1) : 32'h0);
         check({16'h0, cres}, ch == 70 ? 32'h7 : 32'h3);
         check(cspan, ch == 48 ? ecmx_pkg::ONE_F : 32'h40a0_0000);
      end
      reg_wr(ecmx_pkg::G_NEG_ADDR, 32'hc7);
      reg_rd(ecmx_pkg::G_NEG_ADDR, 32'hc7);
      reg_rd(ecmx_pkg::NEG_BASE, 32'hc7);
   endtask
   task automatic t_settle();
      reg_wr(ecmx_pkg::G_SETTLE_ADDR, 32'h47c3_5000);
      reg_rd(ecmx_pkg::G_SETTLE_ADDR, ecmx_pkg::SETTLE_MAX_F);
      reg_wr(ecmx_pkg::G_SETTLE_ADDR, 32'h4000_0000);
      reg_rd(ecmx_pkg::SETTLE_BASE + 16'd44, 32'h4000_0000);
      reg_wr(ecmx_pkg::SETTLE_BASE, ecmx_pkg::ONE_F);
      reg_rd(ecmx_pkg::G_SETTLE_ADDR, ecmx_pkg::MIXED_F);
      job(1'b0, 48, 1'b0, 127);
      job(1'b0, 70, 1'b0, 252);
   endtask
   task automatic t_scan();
      job(1'b1, 60, 1'b1, 2);
      job(1'b1, 61, 1'b0, 127);
      reg_wr(ecmx_pkg::SCAN_SETTLE_ADDR, 32'h4040_0000);
      job(1'b1, 62, 1'b0, 377);
      sreq = 1'b1;
      schan = 7'd20;
      tick();
      sreq = 1'b0;
      tick();
      check({31'h0, busy}, 32'h0);
   endtask
   // ***************************************************************
   // sequence and watchdog
   // ***************************************************************
   initial begin
      repeat (6) @(posedge clk);
      #1;
      rstn = 1'b1;
      t_reset_values();
      t_global_neg();
      t_res_span();
      t_sweep();
      t_settle();
      t_scan();
      report_and_stop();
   end
   initial begin
      #200000;
      fails++;
      report_and_stop();
   end
endmodule
